// ---- verilog/asq_sequencer_ctrl.sv ----
// asq_sequencer_ctrl: four sample sequencers, result queues, triggers, priority, averaging
`timescale 1ns/1ps
module asq_sequencer_ctrl #(
   parameter int NTRIG = 4
) (
   input wire logic sys_clk,
   input wire logic srst,
   input asq_pkg::asq_bus_req_t bus_req,
   output logic [31:0] rd_data,
   input wire logic [NTRIG-1:0] trig_in,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   output logic conv_clk,
   output logic conv_start,
   output asq_pkg::asq_conv_req_t conv_req,
   output logic irq
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [3:0] active_r;
   logic [3:0] mask_r;
   logic [3:0] raw_r;
   logic [3:0] ovf_r;
   logic [3:0] unf_r;
   logic [15:0] trig_sel_r;
   logic [7:0] pri_r;
   logic [2:0] sac_r;
   logic [31:0] mux_r [asq_pkg::NSEQ];
   logic [31:0] ctl_r [asq_pkg::NSEQ];
   logic [3:0] pend_r;
   logic [NTRIG-1:0] trig_s1_r;
   logic [NTRIG-1:0] trig_s2_r;
   logic [NTRIG-1:0] trig_s3_r;
   logic [asq_pkg::DIV_W-1:0] div_r;
   logic conv_clk_r;
   logic conv_start_r;
   asq_pkg::asq_conv_req_t conv_req_r;
   logic irq_r;
   logic [31:0] rd_data_r;
   asq_pkg::asq_state_t state_r;
   logic [1:0] cur_r;
   logic [2:0] slot_r;
   logic [asq_pkg::ACC_W-1:0] acc_r;
   logic [asq_pkg::AVG_W-1:0] avg_r;
   logic [9:0] res_r;
   logic conv_tick;
   logic wr;
   logic rd;
   logic [11:0] addr;
   logic [11:0] rel;
   logic in_seq;
   logic [1:0] sidx;
   logic [4:0] sub;
   logic [3:0] sw_init;
   logic [3:0] trig_evt;
   logic [3:0] pop_stb;
   logic [3:0] ovf_evt;
   logic [3:0] unf_evt;
   logic [9:0] q_out [asq_pkg::NSEQ];
   logic [31:0] q_state [asq_pkg::NSEQ];
   logic push_en;
   logic grant_vld;
   logic [1:0] grant;
   logic [3:0] slot_mux;
   logic [3:0] slot_ctl;
   logic [3:0] cur_depth;
   logic last_slot;
   logic [asq_pkg::AVG_W-1:0] avg_tgt;
   logic [asq_pkg::ACC_W-1:0] acc_sum;
   logic [31:0] rd_val;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr = bus_req.wr;
   assign rd = bus_req.rd;
   assign addr = bus_req.addr;
   assign rel = addr - asq_pkg::SEQ_BASE;
   assign in_seq = (addr >= asq_pkg::SEQ_BASE) && (rel < asq_pkg::SEQ_SPAN);
   assign sidx = rel[6:5];
   assign sub = rel[4:0];
   assign sw_init = (wr && addr == asq_pkg::OFF_SW_INIT) ? bus_req.wdata[3:0] : 4'h0;

   // ----------------------------------------
   // converter clock divider
   // ----------------------------------------
   assign conv_tick = (div_r == asq_pkg::DIV_W'(asq_pkg::CONV_DIV - 1));

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_r <= '0;
         conv_clk_r <= 1'b0;
      end else begin
         div_r <= conv_tick ? '0 : div_r + 4'h1;
         conv_clk_r <= (div_r < asq_pkg::DIV_W'(asq_pkg::CONV_DIV / 2));
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         active_r <= 4'h0;
         mask_r <= 4'h0;
         trig_sel_r <= 16'h0000;
         pri_r <= asq_pkg::PRI_RESET;
         sac_r <= 3'h0;
      end else if (wr) begin
         case (addr)
            asq_pkg::OFF_ACTIVE: active_r <= bus_req.wdata[3:0];
            asq_pkg::OFF_IRQ_MASK: mask_r <= bus_req.wdata[3:0];
            asq_pkg::OFF_TRIG_SEL: trig_sel_r <= bus_req.wdata[15:0];
            asq_pkg::OFF_PRIORITY: begin
               pri_r <= {bus_req.wdata[13:12], bus_req.wdata[9:8],
                  bus_req.wdata[5:4], bus_req.wdata[1:0]};
            end
            asq_pkg::OFF_AVERAGE: begin
               sac_r <= (bus_req.wdata[2:0] > asq_pkg::SAC_MAX) ? asq_pkg::SAC_MAX :
                  bus_req.wdata[2:0];
            end
            default: ;
         endcase
      end
   end

   // slot nibbles stay writable whether or not the sequencer runs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < asq_pkg::NSEQ; i++) begin
            mux_r[i] <= 32'h00000000;
            ctl_r[i] <= (i == asq_pkg::NSEQ - 1) ? asq_pkg::CTL3_RESET : 32'h00000000;
         end
      end else if (wr && in_seq) begin
         if (sub == asq_pkg::SUB_MUX) begin
            mux_r[sidx] <= bus_req.wdata;
         end
         if (sub == asq_pkg::SUB_CTL) begin
            ctl_r[sidx] <= bus_req.wdata;
         end
      end
   end

   // ----------------------------------------
   // triggers and pending requests
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         trig_s1_r <= '0;
         trig_s2_r <= '0;
         trig_s3_r <= '0;
      end else begin
         trig_s1_r <= trig_in;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   always_comb begin
      for (int i = 0; i < asq_pkg::NSEQ; i++) begin
         logic [3:0] code;
         code = trig_sel_r[i*4 +: 4];
         trig_evt[i] = 1'b0;
         if (code == asq_pkg::TRIG_SOFT) begin
            trig_evt[i] = sw_init[i];
         end else if (code == asq_pkg::TRIG_ALWAYS) begin
            trig_evt[i] = 1'b1;
         end else if (int'(code) <= NTRIG) begin
            trig_evt[i] = trig_s2_r[int'(code) - 1] & ~trig_s3_r[int'(code) - 1];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pend_r <= 4'h0;
      end else begin
         for (int i = 0; i < asq_pkg::NSEQ; i++) begin
            if (!active_r[i]) begin
               pend_r[i] <= 1'b0;
            end else if (trig_evt[i]) begin
               pend_r[i] <= 1'b1;
            end else if (state_r == asq_pkg::ST_IDLE && grant_vld && grant == 2'(i)) begin
               pend_r[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // priority arbitration
   // ----------------------------------------
   always_comb begin
      logic [1:0] best;
      best = 2'h3;
      grant_vld = 1'b0;
      grant = 2'h0;
      for (int i = 0; i < asq_pkg::NSEQ; i++) begin
         if (pend_r[i] && active_r[i] && (!grant_vld || pri_r[i*2 +: 2] < best)) begin
            grant_vld = 1'b1;
            grant = 2'(i);
            best = pri_r[i*2 +: 2];
         end
      end
   end

   // ----------------------------------------
   // sequencing engine
   // ----------------------------------------
   assign slot_mux = mux_r[cur_r][{slot_r, 2'b00} +: 4];
   assign slot_ctl = ctl_r[cur_r][{slot_r, 2'b00} +: 4];
   assign cur_depth = asq_pkg::SEQ_DEPTH[{cur_r, 2'b00} +: 4];
   assign last_slot = ({1'b0, slot_r} == cur_depth - 4'h1);
   assign avg_tgt = asq_pkg::AVG_W'(1) << sac_r;
   assign acc_sum = acc_r + {6'h00, conv_data};
   assign push_en = (state_r == asq_pkg::ST_STORE);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= asq_pkg::ST_IDLE;
         cur_r <= 2'h0;
         slot_r <= 3'h0;
         acc_r <= '0;
         avg_r <= '0;
         res_r <= 10'h000;
      end else begin
         case (state_r)
            asq_pkg::ST_IDLE: begin
               if (grant_vld) begin
                  cur_r <= grant;
                  slot_r <= 3'h0;
                  acc_r <= '0;
                  avg_r <= '0;
                  state_r <= asq_pkg::ST_START;
               end
            end
            asq_pkg::ST_START: begin
               if (!active_r[cur_r]) begin
                  state_r <= asq_pkg::ST_IDLE;
               end else if (conv_tick) begin
                  state_r <= asq_pkg::ST_WAIT;
               end
            end
            asq_pkg::ST_WAIT: begin
               if (conv_done) begin
                  if (avg_r == avg_tgt - 7'h01) begin
                     res_r <= 10'(acc_sum >> sac_r);
                     state_r <= asq_pkg::ST_STORE;
                  end else begin
                     acc_r <= acc_sum;
                     avg_r <= avg_r + 7'h01;
                     state_r <= asq_pkg::ST_START;
                  end
               end
            end
            asq_pkg::ST_STORE: begin
               acc_r <= '0;
               avg_r <= '0;
               if (slot_ctl[asq_pkg::CTL_END] || last_slot || !active_r[cur_r]) begin
                  state_r <= asq_pkg::ST_IDLE;
               end else begin
                  slot_r <= slot_r + 3'h1;
                  state_r <= asq_pkg::ST_START;
               end
            end
            default: state_r <= asq_pkg::ST_IDLE;
         endcase
      end
   end

   // converter request, one pulse per conversion, registered the cycle after the converter tick
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         conv_start_r <= 1'b0;
         conv_req_r <= '0;
      end else begin
         conv_start_r <= (state_r == asq_pkg::ST_START) && conv_tick && active_r[cur_r];
         if (state_r == asq_pkg::ST_START) begin
            conv_req_r.chan <= slot_mux;
            conv_req_r.temp <= slot_ctl[asq_pkg::CTL_TEMP];
            conv_req_r.diff <= slot_ctl[asq_pkg::CTL_DIFF];
         end
      end
   end

   // ----------------------------------------
   // result queues
   // ----------------------------------------
   for (genvar g = 0; g < asq_pkg::NSEQ; g++) begin : g_queue
      localparam logic [3:0] DEP = asq_pkg::SEQ_DEPTH[g*4 +: 4];
      logic [9:0] mem_r [asq_pkg::SLOTS];
      logic [asq_pkg::PTR_W-1:0] head_r;
      logic [asq_pkg::PTR_W-1:0] tail_r;
      logic [asq_pkg::CNT_W-1:0] cnt_r;
      logic [asq_pkg::PTR_W-1:0] last_ptr;
      logic push;
      logic push_ok;
      logic pop_ok;
      assign push = push_en && cur_r == 2'(g);
      assign push_ok = push && cnt_r != DEP;
      assign pop_ok = pop_stb[g] && cnt_r != 4'h0;
      assign pop_stb[g] = rd && in_seq && sidx == 2'(g) && sub == asq_pkg::SUB_QUEUE;
      assign ovf_evt[g] = push && cnt_r == DEP;
      assign unf_evt[g] = pop_stb[g] && cnt_r == 4'h0;
      // an empty queue returns the entry popped last
      assign last_ptr = (head_r == 3'h0) ? 3'(DEP - 4'h1) : head_r - 3'h1;
      assign q_out[g] = (cnt_r == 4'h0) ? mem_r[last_ptr] : mem_r[head_r];
      always_comb begin
         q_state[g] = 32'h00000000;
         q_state[g][asq_pkg::QST_TAIL +: asq_pkg::PTR_W] = tail_r;
         q_state[g][asq_pkg::QST_HEAD +: asq_pkg::PTR_W] = head_r;
         q_state[g][asq_pkg::QST_EMPTY] = (cnt_r == 4'h0);
         q_state[g][asq_pkg::QST_FULL] = (cnt_r == DEP);
      end
      always_ff @(posedge sys_clk) begin
         if (push_ok) begin
            mem_r[tail_r] <= res_r;
         end
      end
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            head_r <= '0;
            tail_r <= '0;
            cnt_r <= '0;
         end else begin
            if (push_ok) begin
               tail_r <= (tail_r == 3'(DEP - 4'h1)) ? 3'h0 : tail_r + 3'h1;
            end
            if (pop_ok) begin
               head_r <= (head_r == 3'(DEP - 4'h1)) ? 3'h0 : head_r + 3'h1;
            end
            cnt_r <= cnt_r + {3'h0, push_ok} - {3'h0, pop_ok};
         end
      end
   end

   // ----------------------------------------
   // status flags and interrupt
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         raw_r <= 4'h0;
         ovf_r <= 4'h0;
         unf_r <= 4'h0;
         irq_r <= 1'b0;
      end else begin
         for (int i = 0; i < asq_pkg::NSEQ; i++) begin
            if (push_en && cur_r == 2'(i) && slot_ctl[asq_pkg::CTL_IE]) begin
               raw_r[i] <= 1'b1;
            end else if (wr && addr == asq_pkg::OFF_IRQ_CLR && bus_req.wdata[i]) begin
               raw_r[i] <= 1'b0;
            end
            if (ovf_evt[i]) begin
               ovf_r[i] <= 1'b1;
            end else if (wr && addr == asq_pkg::OFF_OVERFLOW && bus_req.wdata[i]) begin
               ovf_r[i] <= 1'b0;
            end
            if (unf_evt[i]) begin
               unf_r[i] <= 1'b1;
            end else if (wr && addr == asq_pkg::OFF_UNDERFLOW && bus_req.wdata[i]) begin
               unf_r[i] <= 1'b0;
            end
         end
         irq_r <= |(raw_r & mask_r);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      rd_val = 32'h00000000;
      if (in_seq) begin
         case (sub)
            asq_pkg::SUB_MUX: rd_val = mux_r[sidx];
            asq_pkg::SUB_CTL: rd_val = ctl_r[sidx];
            asq_pkg::SUB_QUEUE: rd_val = {22'h000000, q_out[sidx]};
            asq_pkg::SUB_STATE: rd_val = q_state[sidx];
            default: rd_val = 32'h00000000;
         endcase
      end else begin
         case (addr)
            asq_pkg::OFF_ACTIVE: rd_val[3:0] = active_r;
            asq_pkg::OFF_RAW_IRQ: rd_val[3:0] = raw_r;
            asq_pkg::OFF_IRQ_MASK: rd_val[3:0] = mask_r;
            asq_pkg::OFF_IRQ_CLR: rd_val[3:0] = raw_r & mask_r;
            asq_pkg::OFF_OVERFLOW: rd_val[3:0] = ovf_r;
            asq_pkg::OFF_TRIG_SEL: rd_val[15:0] = trig_sel_r;
            asq_pkg::OFF_UNDERFLOW: rd_val[3:0] = unf_r;
            asq_pkg::OFF_PRIORITY: begin
               rd_val = {18'h00000, pri_r[7:6], 2'h0, pri_r[5:4], 2'h0,
                  pri_r[3:2], 2'h0, pri_r[1:0]};
            end
            asq_pkg::OFF_AVERAGE: rd_val[2:0] = sac_r;
            default: rd_val = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data_r <= 32'h00000000;
      end else begin
         rd_data_r <= rd ? rd_val : 32'h00000000;
      end
   end

   assign rd_data = rd_data_r;
   assign conv_clk = conv_clk_r;
   assign conv_start = conv_start_r;
   assign conv_req = conv_req_r;
   assign irq = irq_r;
endmodule // asq_sequencer_ctrl

// ---- pkg/asq_pkg.sv ----
// asq_pkg: constants and types for the sample sequencer control block
package asq_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NSEQ = 4;
   localparam int SLOTS = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int RES_W = 10;
   localparam int NIB_W = 4;
   localparam int PTR_W = 3;
   localparam int CNT_W = 4;
   localparam int PRI_W = 2;
   localparam int SAC_W = 3;
   localparam int ACC_W = 16;
   localparam int AVG_W = 7;
   // per-sequencer slot count and queue depth, sequencer 0 in the low nibble
   localparam logic [15:0] SEQ_DEPTH = {4'h1, 4'h4, 4'h4, 4'h8};
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [11:0] OFF_ACTIVE = 12'h000;
   localparam logic [11:0] OFF_RAW_IRQ = 12'h004;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h00C;
   localparam logic [11:0] OFF_OVERFLOW = 12'h010;
   localparam logic [11:0] OFF_TRIG_SEL = 12'h014;
   localparam logic [11:0] OFF_UNDERFLOW = 12'h018;
   localparam logic [11:0] OFF_PRIORITY = 12'h020;
   localparam logic [11:0] OFF_SW_INIT = 12'h028;
   localparam logic [11:0] OFF_AVERAGE = 12'h030;
   localparam logic [11:0] SEQ_BASE = 12'h040;
   localparam logic [11:0] SEQ_SPAN = 12'h080;
   localparam logic [4:0] SUB_MUX = 5'h00;
   localparam logic [4:0] SUB_CTL = 5'h04;
   localparam logic [4:0] SUB_QUEUE = 5'h08;
   localparam logic [4:0] SUB_STATE = 5'h0C;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int CTL_DIFF = 0;
   localparam int CTL_END = 1;
   localparam int CTL_IE = 2;
   localparam int CTL_TEMP = 3;
   localparam int QST_TAIL = 0;
   localparam int QST_HEAD = 4;
   localparam int QST_EMPTY = 8;
   localparam int QST_FULL = 12;
   localparam logic [7:0] PRI_RESET = 8'hE4;
   localparam logic [31:0] PRI_RESET_WORD = 32'h00003210;
   localparam logic [31:0] CTL3_RESET = 32'h00000002;
   localparam logic [3:0] TRIG_SOFT = 4'h0;
   localparam logic [3:0] TRIG_ALWAYS = 4'hF;
   localparam logic [2:0] SAC_MAX = 3'h6;
   // ----------------------------------------
   // converter clock
   // ----------------------------------------
   localparam int SYS_CLK_HZ = 100000000;
   localparam int CONV_TARGET_HZ = 16667000;
   localparam int CONV_DIV = (SYS_CLK_HZ + CONV_TARGET_HZ / 2) / CONV_TARGET_HZ;
   localparam int DIV_W = 4;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE} asq_state_t;
   typedef struct packed {
      logic temp;
      logic diff;
      logic [3:0] chan;
   } asq_conv_req_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } asq_bus_req_t;
endpackage

// ---- bench/asq_conv_model.sv ----
// asq_conv_model: converter model answering each start after a set delay
`timescale 1ns/1ps
module asq_conv_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic conv_start,
   input asq_pkg::asq_conv_req_t conv_req,
   input wire logic [7:0] delay,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic busy_r;
   logic [7:0] cnt_r;
   always_ff @(posedge sys_clk) begin
      conv_done <= 1'b0;
      if (srst) begin
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
      end else if (conv_start) begin
         busy_r <= 1'b1;
         cnt_r <= delay;
      end else if (busy_r && cnt_r == 8'h00) begin
         busy_r <= 1'b0;
         conv_done <= 1'b1;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // result tied to the selected input, inverted outside the done pulse
   assign conv_data = conv_done ? {4'hA, conv_req} : ~{4'hA, conv_req};
endmodule // asq_conv_model

// ---- bench/asq_seq_monitor.sv ----
// asq_seq_monitor: port assertions for the sample sequencer control block
`timescale 1ns/1ps
module asq_seq_monitor #(
   parameter int NTRIG = 4
) (
   input wire logic sys_clk,
   input wire logic srst,
   input asq_pkg::asq_bus_req_t bus_req,
   input wire logic [31:0] rd_data,
   input wire logic [NTRIG-1:0] trig_in,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   input wire logic conv_clk,
   input wire logic conv_start,
   input asq_pkg::asq_conv_req_t conv_req,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic busy_r;
   logic [3:0] act_r;
   logic [2:0] wr_age_r;
   logic [2:0] done_age_r;
   logic qrd;
   assign qrd = bus_req.rd && bus_req.addr >= 12'h040 && bus_req.addr < 12'h0C0
      && bus_req.addr[4:0] == 5'h08;
   always_ff @(posedge sys_clk) begin
      if (srst || conv_done) busy_r <= 1'b0;
      else if (conv_start) busy_r <= 1'b1;
      if (srst) act_r <= 4'h0;
      else if (bus_req.wr && bus_req.addr == 12'h000) act_r <= bus_req.wdata[3:0];
      if (srst || bus_req.wr) wr_age_r <= 3'h0;
      else if (wr_age_r != 3'h7) wr_age_r <= wr_age_r + 3'h1;
      if (srst || conv_done) done_age_r <= 3'h0;
      else if (done_age_r != 3'h7) done_age_r <= done_age_r + 3'h1;
   end
   rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
      else $error("read data not zero");
   queue_word_a: assert property ($past(qrd) |-> rd_data[31:10] == 22'h0)
      else $error("queue word upper bits set");
   one_conv_a: assert property (busy_r |-> !conv_start)
      else $error("start while converting");
   req_hold_a: assert property (busy_r |-> $stable(conv_req))
      else $error("slot selection moved");
   clk_period_a: assert property ($rose(conv_clk) |-> ##6 $rose(conv_clk))
      else $error("converter clock period");
   reset_quiet_a: assert property ($fell(srst) |-> !irq && !conv_start)
      else $error("outputs active after reset");
   off_quiet_a: assert property (act_r == 4'h0 && $past(act_r) == 4'h0
      && $past(act_r, 2) == 4'h0 |-> !conv_start)
      else $error("start with no sequencer on");
   irq_cause_a: assert property ($rose(irq) |-> wr_age_r < 3'h4 || done_age_r < 3'h4)
      else $error("irq rose without cause");
   irq_clear_a: assert property ($fell(irq) |-> wr_age_r < 3'h4)
      else $error("irq fell without write");
   conv_c: cover property (conv_start);
   irq_c: cover property ($rose(irq));
   pop_c: cover property (qrd);
endmodule // asq_seq_monitor

// ---- bench/asq_sequencer_ctrl_bench.sv ----
// asq_sequencer_ctrl_bench: self-checking bench for the sample sequencer control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module asq_sequencer_ctrl_bench;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
   } asq_row_t;
   logic sys_clk;
   logic srst;
   asq_pkg::asq_bus_req_t bus_req;
   logic [31:0] rd_data;
   logic [3:0] trig_in;
   logic conv_done;
   logic [9:0] conv_data;
   logic conv_clk;
   logic conv_start;
   asq_pkg::asq_conv_req_t conv_req;
   logic irq;
   logic [7:0] dly;
   logic [31:0] v;
   int error_cnt = 0;
   int n_compared = 0;
   int done_cnt = 0;
   int n;
   asq_pkg::asq_conv_req_t reqs[$];
   logic [3:0] chs[3] = '{4'h1, 4'h1, 4'h3};
   asq_row_t rows[16] = '{'{12'h000, 0}, '{12'h004, 0}, '{12'h008, 0}, '{12'h00C, 0},
      '{12'h010, 0}, '{12'h014, 0}, '{12'h018, 0}, '{12'h020, asq_pkg::PRI_RESET_WORD},
      '{12'h030, 0}, '{12'h044, 0}, '{12'h0A4, asq_pkg::CTL3_RESET}, '{12'h04C, 32'h100},
      '{12'h06C, 32'h100}, '{12'h08C, 32'h100}, '{12'h0AC, 32'h100}, '{12'h100, 0}};
   asq_sequencer_ctrl dut_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
      .rd_data(rd_data), .trig_in(trig_in), .conv_done(conv_done), .conv_data(conv_data),
      .conv_clk(conv_clk), .conv_start(conv_start), .conv_req(conv_req), .irq(irq));
   asq_conv_model conv_u (.sys_clk(sys_clk), .srst(srst), .conv_start(conv_start),
      .conv_req(conv_req), .delay(dly), .conv_done(conv_done), .conv_data(conv_data));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (conv_done) done_cnt <= done_cnt + 1;
      if (conv_start) reqs.push_back(conv_req);
   end
   function automatic logic [11:0] sa(input int s, input logic [4:0] sub);
      return asq_pkg::SEQ_BASE + 12'(s * 32) + {7'h00, sub};
   endfunction
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 `CHK(nm, e, rd_data)
      @(posedge sys_clk);
   endtask
   task automatic wait_done(input int k);
      for (int i = 0; i < 600 && done_cnt < k; i++) @(posedge sys_clk);
      if (done_cnt < k) begin
         error_cnt++;
         $display("BAD conversions exp %0d got %0d", k, done_cnt);
         close_out();
      end
      repeat (30) @(posedge sys_clk);
   endtask
   initial begin
      srst = 1'b1;
      bus_req = '0;
      trig_in = 4'h0;
      dly = 8'h03;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      foreach (rows[i]) rd_chk("reset value", rows[i].a, rows[i].d);
      bus_wr(asq_pkg::OFF_SW_INIT, 32'h1);
      repeat (60) @(posedge sys_clk);
      `CHK("starts while off", 0, reqs.size())
      $display("test reset done");
      dly <= 8'h28;
      bus_wr(sa(0, asq_pkg::SUB_MUX), 32'h2311);
      bus_wr(sa(0, asq_pkg::SUB_CTL), 32'h2604);
      bus_wr(asq_pkg::OFF_IRQ_MASK, 32'h1);
      bus_wr(asq_pkg::OFF_ACTIVE, 32'h1);
      n = done_cnt;
      bus_wr(asq_pkg::OFF_SW_INIT, 32'h1);
      wait_done(n + 3);
      repeat (60) @(posedge sys_clk);
      `CHK("slots run", 3, reqs.size())
      `CHK("irq", 1'b1, irq)
      rd_chk("raw", asq_pkg::OFF_RAW_IRQ, 32'h1);
      rd_chk("masked", asq_pkg::OFF_IRQ_CLR, 32'h1);
      rd_chk("state", sa(0, asq_pkg::SUB_STATE), 32'h003);
      foreach (chs[k]) rd_chk("pop", sa(0, asq_pkg::SUB_QUEUE), {22'h0, 6'h28, chs[k]});
      rd_chk("state", sa(0, asq_pkg::SUB_STATE), 32'h133);
      bus_wr(asq_pkg::OFF_IRQ_CLR, 32'h0);
      rd_chk("raw kept", asq_pkg::OFF_RAW_IRQ, 32'h1);
      bus_wr(asq_pkg::OFF_IRQ_CLR, 32'h1);
      rd_chk("raw cleared", asq_pkg::OFF_RAW_IRQ, 32'h0);
      `CHK("irq low", 1'b0, irq)
      rd_chk("extra pop", sa(0, asq_pkg::SUB_QUEUE), {22'h0, 6'h28, 4'h3});
      rd_chk("underflow", asq_pkg::OFF_UNDERFLOW, 32'h1);
      bus_wr(asq_pkg::OFF_UNDERFLOW, 32'h1);
      rd_chk("underflow clr", asq_pkg::OFF_UNDERFLOW, 32'h0);
      $display("test sequence done");
      dly <= 8'h02;
      bus_wr(asq_pkg::OFF_ACTIVE, 32'h8);
      bus_wr(asq_pkg::OFF_TRIG_SEL, 32'h1000);
      for (int t = 0; t < 2; t++) begin
         n = done_cnt;
         trig_in <= 4'h1;
         repeat (4) @(posedge sys_clk);
         trig_in <= 4'h0;
         wait_done(n + 1);
      end
      rd_chk("overflow", asq_pkg::OFF_OVERFLOW, 32'h8);
      rd_chk("one entry", sa(3, asq_pkg::SUB_QUEUE), 32'h280);
      $display("test overflow done");
      bus_wr(asq_pkg::OFF_PRIORITY, 32'h3012);
      bus_wr(sa(1, asq_pkg::SUB_MUX), 32'h1);
      bus_wr(sa(2, asq_pkg::SUB_MUX), 32'h2);
      bus_wr(sa(1, asq_pkg::SUB_CTL), 32'h2);
      bus_wr(sa(2, asq_pkg::SUB_CTL), 32'h2);
      bus_wr(asq_pkg::OFF_ACTIVE, 32'h6);
      reqs.delete();
      n = done_cnt;
      bus_wr(asq_pkg::OFF_SW_INIT, 32'h6);
      wait_done(n + 2);
      `CHK("first served", 4'h2, reqs[0].chan)
      `CHK("second served", 4'h1, reqs[1].chan)
      $display("test priority done");
      bus_wr(asq_pkg::OFF_TRIG_SEL, 32'hF000);
      bus_wr(asq_pkg::OFF_ACTIVE, 32'h8);
      reqs.delete();
      n = done_cnt;
      wait_done(n + 3);
      bus_wr(asq_pkg::OFF_ACTIVE, 32'h0);
      `CHK("always runs", 1'b1, reqs.size() >= 3)
      rd_chk("always overflow", asq_pkg::OFF_OVERFLOW, 32'h8);
      $display("test always done");
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rd_chk("priority", asq_pkg::OFF_PRIORITY, asq_pkg::PRI_RESET_WORD);
      $display("test second reset done");
      close_out();
   end
endmodule // asq_sequencer_ctrl_bench
bind asq_sequencer_ctrl asq_seq_monitor #(.NTRIG(NTRIG)) mon_u (.sys_clk(sys_clk),
   .srst(srst), .bus_req(bus_req), .rd_data(rd_data), .trig_in(trig_in),
   .conv_done(conv_done), .conv_data(conv_data), .conv_clk(conv_clk),
   .conv_start(conv_start), .conv_req(conv_req), .irq(irq));
